// >>> common/sas_pkg.sv
package sas_pkg;
  typedef enum logic [1:0] {
    SAS_IDLE = 2'b00,
    SAS_ACQ  = 2'b01,
    SAS_CONV = 2'b10,
    SAS_HOLD = 2'b11
  } sas_state_t;

  typedef struct packed {
    logic       sample;
    logic       convert;
    logic [3:0] chan;
    logic       vref_pos_ext;
    logic       vref_neg_ext;
    logic [9:0] trial;
  } sas_afe_t;
endpackage

// >>> common/sas_regs.svh
`ifndef SAS_REGS_SVH
`define SAS_REGS_SVH
// ********************
// register offsets
// ********************
`define SAS_OFS_CTL0    8'h00
`define SAS_OFS_CTL1    8'h04
`define SAS_OFS_CTL2    8'h08
`define SAS_OFS_RESH    8'h0C
`define SAS_OFS_RESL    8'h10
`define SAS_OFS_IRQ     8'h14
// ********************
// field positions
// ********************
`define SAS_CTL0_ON     0
`define SAS_CTL0_GO     1
`define SAS_CTL0_CH_LO  2
`define SAS_CTL0_CH_HI  5
`define SAS_CTL1_PC_LO  0
`define SAS_CTL1_PC_HI  3
`define SAS_CTL1_VPOS   4
`define SAS_CTL1_VNEG   5
`define SAS_CTL2_CS_LO  0
`define SAS_CTL2_CS_HI  2
`define SAS_CTL2_AQ_LO  3
`define SAS_CTL2_AQ_HI  5
`define SAS_CTL2_RJ     7
`define SAS_IRQ_FLAG    0
`define SAS_IRQ_EN      1
`define SAS_IRQ_GIE     2
// ********************
// reset values
// ********************
`define SAS_CTL0_RST    8'h00
`define SAS_CTL1_RST    8'h00
`define SAS_CTL2_RST    8'h00
`define SAS_IRQ_RST     3'h0
// ********************
// timing
// ********************
`define SAS_PCLK_NS     4
`define SAS_RC_TAD_NS   4000
`define SAS_RC_TAD_CYC  (`SAS_RC_TAD_NS / `SAS_PCLK_NS)
`define SAS_TCY_CYC     4
`define SAS_HOLD_TADS   5'h02
`define SAS_SAR_LAST    4'hA
`endif

// >>> rtl/sas_sar_core.sv
`timescale 1ns/1ps
`include "sas_regs.svh"
module sas_sar_core (
  input  wire logic       pclk,    // device clock
  input  wire logic       presetn, // async reset
  input  wire logic       start,   // begin conversion
  input  wire logic       abort,   // drop conversion
  input  wire logic       tick,    // bit period tick
  input  wire logic       comp_hi, // input at or above trial
  output logic            done,    // one-cycle completion
  output logic [9:0]      trial,   // trial code to dac
  output logic [9:0]      result   // completed code
);
  logic [3:0] bitn, next_bitn;
  logic [9:0] next_trial, next_result;
  logic       busy, next_busy, next_done;

  always_comb begin
    next_bitn   = bitn;
    next_trial  = trial;
    next_result = result;
    next_busy   = busy;
    next_done   = 1'b0;
    if (abort) begin
      next_busy = 1'b0;
    end else if (start) begin
      next_busy  = 1'b1;
      next_bitn  = 4'h0;
      next_trial = 10'h200;
    end else if (busy && tick) begin
      next_bitn = bitn + 4'h1;
      if (bitn == `SAS_SAR_LAST) begin
        next_busy   = 1'b0;
        next_done   = 1'b1;
        next_result = trial;
      end else begin
        // keep or drop the bit under test, then try the next one
        if (!comp_hi)
          next_trial[4'h9 - bitn] = 1'b0;
        if (bitn != 4'h9)
          next_trial[4'h8 - bitn] = 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bitn   <= 4'h0;
      trial  <= 10'h000;
      result <= 10'h000;
      busy   <= 1'b0;
      done   <= 1'b0;
    end else begin
      bitn   <= next_bitn;
      trial  <= next_trial;
      result <= next_result;
      busy   <= next_busy;
      done   <= next_done;
    end
  end

  AST_ELEVEN_TADS: assert property (@(posedge pclk) disable iff (!presetn)
    (busy && tick && !abort && !start && bitn == `SAS_SAR_LAST) |=> done)
    else $error("conversion did not end on the eleventh bit period");
endmodule // sas_sar_core

// >>> rtl/sas_tad_gen.sv
`timescale 1ns/1ps
`include "sas_regs.svh"
module sas_tad_gen (
  input  wire logic       pclk,    // device clock
  input  wire logic       presetn, // async reset
  input  wire logic       run,     // sequencer active
  input  wire logic       sleep,   // device in sleep
  input  wire logic [2:0] csel,    // clock select
  output logic            tick     // one bit period elapsed
);
  logic [9:0] cnt, next_cnt;
  logic [2:0] dly, next_dly;
  logic       next_tick;
  logic       rc;

  function automatic logic [9:0] tad_len(input logic [2:0] s);
    unique case (s)
      3'h0: tad_len = 10'h002;
      3'h1: tad_len = 10'h008;
      3'h2: tad_len = 10'h020;
      3'h4: tad_len = 10'h004;
      3'h5: tad_len = 10'h010;
      3'h6: tad_len = 10'h040;
      3'h3, 3'h7: tad_len = 10'(`SAS_RC_TAD_CYC);
    endcase
  endfunction

  assign rc = (csel[1:0] == 2'h3);

  always_comb begin
    next_tick = 1'b0;
    next_cnt  = cnt;
    next_dly  = dly;
    if (!run) begin
      next_cnt = 10'h000;
      // rc source starts one instruction cycle late
      next_dly = rc ? 3'(`SAS_TCY_CYC) : 3'h0;
    end else if (sleep && !rc) begin
      // device clock is stopped in sleep
    end else if (dly != 3'h0) begin
      next_dly = dly - 3'h1;
    end else if (cnt == tad_len(csel) - 10'h001) begin
      next_cnt  = 10'h000;
      next_tick = 1'b1;
    end else begin
      next_cnt = cnt + 10'h001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt  <= 10'h000;
      dly  <= 3'h0;
      tick <= 1'b0;
    end else begin
      cnt  <= next_cnt;
      dly  <= next_dly;
      tick <= next_tick;
    end
  end

  AST_SLEEP_RC_ONLY: assert property (@(posedge pclk) disable iff (!presetn)
    (sleep && !rc) |=> !tick)
    else $error("bit period advanced in sleep without rc clock");
endmodule // sas_tad_gen

// >>> rtl/sas_top.sv
`timescale 1ns/1ps
`include "sas_regs.svh"
// ************************************************
// ************************************************
module sas_top (
  input  wire logic              pclk,            // 250 MHz clock
  input  wire logic              presetn,         // async reset
  input  wire logic              psel,            // apb select
  input  wire logic              penable,         // apb enable
  input  wire logic              pwrite,          // apb write
  input  wire logic [7:0]        paddr,           // apb address
  input  wire logic [31:0]       pwdata,          // apb write data
  output logic [31:0]            prdata,          // apb read data
  output logic                   pready,          // apb ready
  output logic                   pslverr,         // apb error
  input  wire logic              sleep,           // device in sleep
  input  wire logic              comp_hi,         // comparator result
  output sas_pkg::sas_afe_t      afe,             // analog front end
  output logic [11:0]            analog_pin_mask, // 1 = analog input
  output logic                   irq              // completion irq
);
  // ************************************************
  // state
  // ************************************************
  logic        on, go, vpos, vneg, rjust, flag, ien, global_irq_enable;
  logic [3:0]  chan, pcfg;
  logic [2:0]  acq, csel;
  logic        next_on, next_go, next_vpos, next_vneg, next_rjust;
  logic        next_flag, next_ien, next_gie;
  logic [3:0]  next_chan, next_pcfg;
  logic [2:0]  next_acq, next_csel;
  logic [31:0] next_prdata;
  logic        next_pready, next_pslverr, next_irq;
  logic [11:0] next_mask;
  logic [7:0]  res_h, res_l, next_res_h, next_res_l;
  sas_pkg::sas_state_t state, next_state;
  logic [4:0]  cnt, next_cnt;
  logic        sample, conv, next_sample, next_conv;
  logic        tick, done, start_conv, abort, wr, setup;
  logic [9:0]  trial, result;

  // ************************************************
  // helpers
  // ************************************************
  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == `SAS_OFS_CTL0) || (a == `SAS_OFS_CTL1) ||
             (a == `SAS_OFS_CTL2) || (a == `SAS_OFS_RESH) ||
             (a == `SAS_OFS_RESL) || (a == `SAS_OFS_IRQ);
  endfunction

  function automatic logic [4:0] acq_tads(input logic [2:0] f);
    unique case (f)
      3'h0: acq_tads = 5'h00;
      3'h1: acq_tads = 5'h02;
      3'h2: acq_tads = 5'h04;
      3'h3: acq_tads = 5'h06;
      3'h4: acq_tads = 5'h08;
      3'h5: acq_tads = 5'h0C;
      3'h6: acq_tads = 5'h10;
      3'h7: acq_tads = 5'h14;
    endcase
  endfunction

  assign setup = psel && !penable;
  assign wr    = psel && penable && pready && pwrite && mapped(paddr);

  // ************************************************
  // register file and apb
  // ************************************************
  always_comb begin
    next_on      = on;
    next_go      = go;
    next_chan    = chan;
    next_vpos    = vpos;
    next_vneg    = vneg;
    next_pcfg    = pcfg;
    next_rjust   = rjust;
    next_acq     = acq;
    next_csel    = csel;
    next_flag    = flag;
    next_ien     = ien;
    next_gie     = global_irq_enable;
    next_prdata  = 32'h0000_0000;
    next_pready  = setup;
    next_pslverr = setup && !mapped(paddr);
    if (wr) begin
      unique case (paddr)
        `SAS_OFS_CTL0: begin
          next_on   = pwdata[`SAS_CTL0_ON];
          // go only arms on an already enabled converter
          next_go   = pwdata[`SAS_CTL0_GO] && on && pwdata[`SAS_CTL0_ON];
          next_chan = pwdata[`SAS_CTL0_CH_HI:`SAS_CTL0_CH_LO];
        end
        `SAS_OFS_CTL1: begin
          next_vpos = pwdata[`SAS_CTL1_VPOS];
          next_vneg = pwdata[`SAS_CTL1_VNEG];
          next_pcfg = pwdata[`SAS_CTL1_PC_HI:`SAS_CTL1_PC_LO];
        end
        `SAS_OFS_CTL2: begin
          next_rjust = pwdata[`SAS_CTL2_RJ];
          next_acq   = pwdata[`SAS_CTL2_AQ_HI:`SAS_CTL2_AQ_LO];
          next_csel  = pwdata[`SAS_CTL2_CS_HI:`SAS_CTL2_CS_LO];
        end
        `SAS_OFS_IRQ: begin
          next_flag = pwdata[`SAS_IRQ_FLAG];
          next_ien  = pwdata[`SAS_IRQ_EN];
          next_gie  = pwdata[`SAS_IRQ_GIE];
        end
        default: begin
        end
      endcase
    end
    if (done) begin
      next_go   = 1'b0;
      // set wins over a same-cycle software clear
      next_flag = 1'b1;
    end
    if (setup && !pwrite) begin
      unique case (paddr)
        // go alone reports progress; acquisition is invisible
        `SAS_OFS_CTL0: next_prdata[5:0] = {chan, go, on};
        `SAS_OFS_CTL1: next_prdata[5:0] = {vneg, vpos, pcfg};
        `SAS_OFS_CTL2: next_prdata[7:0] = {rjust, 1'b0, acq, csel};
        `SAS_OFS_RESH: next_prdata[7:0] = res_h;
        `SAS_OFS_RESL: next_prdata[7:0] = res_l;
        `SAS_OFS_IRQ:  next_prdata[2:0] = {global_irq_enable, ien, flag};
        default:       next_prdata = 32'h0000_0000;
      endcase
    end
    next_irq = next_flag && next_ien && next_gie;
  end

  // every control bit returns to its reset value
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      on      <= 1'(`SAS_CTL0_RST >> `SAS_CTL0_ON);
      go      <= 1'b0;
      chan    <= 4'h0;
      vpos    <= 1'b0;
      vneg    <= 1'b0;
      pcfg    <= 4'(`SAS_CTL1_RST >> `SAS_CTL1_PC_LO);
      rjust   <= 1'b0;
      acq     <= 3'(`SAS_CTL2_RST >> `SAS_CTL2_AQ_LO);
      csel    <= 3'h0;
      {global_irq_enable, ien, flag} <= `SAS_IRQ_RST;
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
      irq     <= 1'b0;
    end else begin
      on      <= next_on;
      go      <= next_go;
      chan    <= next_chan;
      vpos    <= next_vpos;
      vneg    <= next_vneg;
      pcfg    <= next_pcfg;
      rjust   <= next_rjust;
      acq     <= next_acq;
      csel    <= next_csel;
      flag    <= next_flag;
      ien     <= next_ien;
      global_irq_enable     <= next_gie;
      prdata  <= next_prdata;
      pready  <= next_pready;
      pslverr <= next_pslverr;
      irq     <= next_irq;
    end
  end

  // ************************************************
  // result pair: no reset, contents undefined at power-on
  // ************************************************
  always_comb begin
    next_res_h = res_h;
    next_res_l = res_l;
    if (wr && paddr == `SAS_OFS_RESH)
      next_res_h = pwdata[7:0];
    if (wr && paddr == `SAS_OFS_RESL)
      next_res_l = pwdata[7:0];
    if (done) begin
      // an aborted conversion never reaches here
      if (rjust) begin
        next_res_h = {6'h00, result[9:8]};
        next_res_l = result[7:0];
      end else begin
        next_res_h = result[9:2];
        next_res_l = {result[1:0], 6'h00};
      end
    end
  end

  always_ff @(posedge pclk) begin
    res_h <= next_res_h;
    res_l <= next_res_l;
  end

  // ************************************************
  // sequencer
  // ************************************************
  always_comb begin
    next_state = state;
    next_cnt   = cnt;
    unique case (state)
      sas_pkg::SAS_IDLE: begin
        if (go) begin
          if (acq == 3'h0) begin
            next_state = sas_pkg::SAS_CONV;
          end else begin
            next_state = sas_pkg::SAS_ACQ;
            next_cnt   = acq_tads(acq);
          end
        end
      end
      sas_pkg::SAS_ACQ: begin
        if (!go) begin
          next_state = sas_pkg::SAS_HOLD;
          next_cnt   = `SAS_HOLD_TADS;
        end else if (tick) begin
          next_cnt = cnt - 5'h01;
          if (cnt == 5'h01)
            next_state = sas_pkg::SAS_CONV;
        end
      end
      sas_pkg::SAS_CONV: begin
        if (done || !go) begin
          next_state = sas_pkg::SAS_HOLD;
          next_cnt   = `SAS_HOLD_TADS;
        end
      end
      sas_pkg::SAS_HOLD: begin
        if (tick) begin
          next_cnt = cnt - 5'h01;
          if (cnt == 5'h01)
            next_state = sas_pkg::SAS_IDLE;
        end
      end
    endcase
    // switching off drops whatever is running
    if (!on)
      next_state = sas_pkg::SAS_IDLE;
    next_sample = next_on && (next_state == sas_pkg::SAS_IDLE ||
                              next_state == sas_pkg::SAS_ACQ);
    next_conv   = next_state == sas_pkg::SAS_CONV;
  end

  assign start_conv = (next_state == sas_pkg::SAS_CONV) &&
                      (state != sas_pkg::SAS_CONV);
  assign abort      = (state == sas_pkg::SAS_CONV) && !go;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state  <= sas_pkg::SAS_IDLE;
      cnt    <= 5'h00;
      sample <= 1'b0;
      conv   <= 1'b0;
    end else begin
      state  <= next_state;
      cnt    <= next_cnt;
      sample <= next_sample;
      conv   <= next_conv;
    end
  end

  // pin mode decode: higher codes turn top pins digital
  genvar gi;
  for (gi = 0; gi < 12; gi++) begin : g_pin
    assign next_mask[gi] = (5'(gi) + {1'b0, next_pcfg}) < 5'h0F;
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
        analog_pin_mask[gi] <= 1'b1;
      else
        analog_pin_mask[gi] <= next_mask[gi];
    end
  end

  assign afe = '{sample, conv, chan, vpos, vneg, trial};

  // ************************************************
  // submodules
  // ************************************************
  sas_tad_gen u_tad (
    .pclk    (pclk),
    .presetn (presetn),
    .run     (state != sas_pkg::SAS_IDLE),
    .sleep   (sleep),
    .csel    (csel),
    .tick    (tick)
  );

  sas_sar_core u_sar (
    .pclk    (pclk),
    .presetn (presetn),
    .start   (start_conv),
    .abort   (abort),
    .tick    (tick),
    .comp_hi (comp_hi),
    .done    (done),
    .trial   (trial),
    .result  (result)
  );

  // ************************************************
  // assertions
  // ************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_done;
    done;
  endsequence
  sequence s_after_done;
    !go && flag && state == sas_pkg::SAS_HOLD;
  endsequence

  AST_DONE_EFFECTS: assert property (s_done |=> s_after_done)
    else $error("completion did not clear go and set flag");
  AST_HOLD_TWO: assert property ((s_done and on) |=> cnt == 5'h02)
    else $error("hold-off not two bit periods");
  AST_GO_NEEDS_ON: assert property (!on |=> !go)
    else $error("go set while converter off");
  AST_ZERO_ACQ: assert property (state == sas_pkg::SAS_IDLE && go && on && acq == 3'h0
    |=> state == sas_pkg::SAS_CONV)
    else $error("zero acquisition did not convert at once");
  AST_PROG_ACQ: assert property (state == sas_pkg::SAS_IDLE && go && on && acq != 3'h0
    |=> state == sas_pkg::SAS_ACQ && cnt == acq_tads($past(acq)))
    else $error("programmed acquisition not loaded");
  AST_RESUME: assert property (state == sas_pkg::SAS_HOLD && tick && cnt == 5'h01 && on
    |=> sample)
    else $error("sampling did not resume");
  AST_ABORT_KEEP: assert property (abort && !wr |=> $stable(res_h) && $stable(res_l))
    else $error("abort changed result");
  AST_IRQ: assert property (flag && ien && global_irq_enable |-> ##[0:1] irq)
    else $error("irq not raised");
  AST_FLAG_STICKY: assert property (flag && !wr |=> flag)
    else $error("flag dropped without software");
  AST_REF: assert property (wr && paddr == `SAS_OFS_CTL1 |=>
    afe.vref_pos_ext == $past(pwdata[`SAS_CTL1_VPOS]) &&
    afe.vref_neg_ext == $past(pwdata[`SAS_CTL1_VNEG]))
    else $error("reference select not driven");
endmodule // sas_top

// >>> tb/sar_adc_sequencer_bench.sv
`timescale 1ns/1ps
`include "sas_regs.svh"
module sar_adc_sequencer_bench;
  logic              pclk = 1'b0;
  logic              presetn = 1'b0;
  logic              psel = 1'b0;
  logic              penable = 1'b0;
  logic              pwrite = 1'b0;
  logic              sleep = 1'b0;
  logic [7:0]        paddr = 8'h00;
  logic [31:0]       pwdata = 32'h0;
  logic [31:0]       prdata;
  logic              pready;
  logic              pslverr;
  logic              comp_hi;
  logic              irq;
  logic [11:0]       analog_pin_mask;
  sas_pkg::sas_afe_t afe;
  logic [9:0]        vin = 10'h000;
  logic [31:0]       q;
  logic              e;
  logic [7:0]        rh;
  logic [7:0]        rl;
  int                err_count = 0;
  int                num_checks = 0;
  logic [2:0]        selv [8] = '{3'h0, 3'h4, 3'h1, 3'h5, 3'h2, 3'h6, 3'h0, 3'h4};
  logic [9:0]        vinv [8] = '{10'h2A5, 10'h15A, 10'h3FF, 10'h000,
                                  10'h201, 10'h1FF, 10'h0AA, 10'h355};

  always #2 pclk = ~pclk;

  sas_top dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sleep(sleep), .comp_hi(comp_hi), .afe(afe), .analog_pin_mask(analog_pin_mask),
    .irq(irq)
  );
  sas_cmp_model cmp_u (.afe(afe), .vin(vin), .comp_hi(comp_hi));

  // ********************
  // shared tasks
  // ********************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic inr(input int v, input int lo, input int hi);
    chk(32'(v >= lo && v <= hi), 32'h1);
  endtask

  // pready and read data are taken at the rising edge that ends the access phase
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 40);
    if (n >= 40) chk(32'h0, 32'h1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk(q, exp);
  endtask

  function automatic int tadv(input logic [2:0] s);
    case (s)
      3'h0: return 2;
      3'h1: return 8;
      3'h2: return 32;
      3'h4: return 4;
      3'h5: return 16;
      3'h6: return 64;
      default: return `SAS_RC_TAD_CYC;
    endcase
  endfunction

  // ********************
  // one full conversion
  // ********************
  task automatic conv(input logic [2:0] sel, input logic [2:0] acq, input logic rj);
    int s, c, h, t, a, d;
    int aq [8] = '{0, 2, 4, 6, 8, 12, 16, 20};
    t = tadv(sel);
    a = aq[acq];
    // the rc clock starts one instruction cycle late
    d = (sel[1:0] == 2'h3) ? `SAS_TCY_CYC : 0;
    s = 0;
    c = 0;
    h = 0;
    wr(`SAS_OFS_CTL2, 32'({rj, 1'b0, acq, sel}));
    wr(`SAS_OFS_CTL0, 32'h17);
    while (afe.convert !== 1'b1 && s < 30000) begin
      @(negedge pclk);
      s++;
    end
    inr(s, a * t - 3, a * t + 6 + d);
    chk(afe.sample, 1'b0);
    while (afe.convert === 1'b1 && c < 30000) begin
      @(negedge pclk);
      c++;
    end
    inr(c, 11 * t - 2, 11 * t + 2 + d);
    while (afe.sample !== 1'b1 && h < 5000) begin
      @(negedge pclk);
      h++;
    end
    inr(h, 2 * t - 1, 2 * t + 2);
    chk(afe.chan, 4'h5);
    rh = rj ? {6'h00, vin[9:8]} : vin[9:2];
    rl = rj ? vin[7:0] : {vin[1:0], 6'h00};
    rc(`SAS_OFS_RESH, 32'(rh));
    rc(`SAS_OFS_RESL, 32'(rl));
    rc(`SAS_OFS_CTL0, 32'h15);
    rc(`SAS_OFS_IRQ, 32'h7);
    chk(irq, 1'b1);
  endtask

  task tally_and_finish;
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial begin
    #200000;
    err_count++;
    tally_and_finish;
  end

  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rc(`SAS_OFS_CTL0, 32'h0);
    rc(`SAS_OFS_CTL2, 32'h0);
    rc(`SAS_OFS_IRQ, 32'h0);
    chk(analog_pin_mask, 12'hFFF);
    rc(8'h18, 32'h0);
    chk(e, 1'b1);
    // pin modes and reference sources
    for (int p = 0; p < 16; p++) begin
      wr(`SAS_OFS_CTL1, 32'(p | ((p & 3) << 4)));
      @(negedge pclk);
      chk(analog_pin_mask, p < 4 ? 12'hFFF : 12'hFFF >> (p - 3));
      chk(afe.vref_pos_ext, p[0]);
      chk(afe.vref_neg_ext, p[1]);
    end
    wr(`SAS_OFS_CTL1, 32'h0);
    // go with the converter off
    wr(`SAS_OFS_CTL0, 32'h2);
    rc(`SAS_OFS_CTL0, 32'h0);
    chk(afe.convert, 1'b0);
    rc(`SAS_OFS_IRQ, 32'h0);
    // go in the same write that turns the converter on
    wr(`SAS_OFS_CTL0, 32'h3);
    rc(`SAS_OFS_CTL0, 32'h1);
    wr(`SAS_OFS_CTL0, 32'h15);
    repeat (8) @(posedge pclk);
    wr(`SAS_OFS_IRQ, 32'h6);
    for (int i = 0; i < 8; i++) begin
      vin <= vinv[i];
      conv(selv[i], 3'(i), i[0]);
      wr(`SAS_OFS_IRQ, 32'h6);
      rc(`SAS_OFS_IRQ, 32'h6);
    end
    // sleep: divided clock stalls, rc clock converts
    sleep <= 1'b1;
    wr(`SAS_OFS_CTL2, 32'h80);
    wr(`SAS_OFS_CTL0, 32'h17);
    repeat (100) @(negedge pclk);
    rc(`SAS_OFS_CTL0, 32'h17);
    rc(`SAS_OFS_IRQ, 32'h6);
    wr(`SAS_OFS_CTL0, 32'h15);
    rc(`SAS_OFS_RESH, 32'(rh));
    rc(`SAS_OFS_RESL, 32'(rl));
    rc(`SAS_OFS_IRQ, 32'h6);
    chk(afe.convert, 1'b0);
    // the hold-off is stalled too; let it run out on the device clock
    sleep <= 1'b0;
    repeat (8) @(posedge pclk);
    chk(afe.sample, 1'b1);
    sleep <= 1'b1;
    vin <= 10'h1C3;
    conv(3'h3, 3'h0, 1'b1);
    sleep <= 1'b0;
    // reset in mid conversion
    conv(3'h7, 3'h0, 1'b0);
    wr(`SAS_OFS_CTL1, 32'h0F);
    wr(`SAS_OFS_CTL2, 32'h06);
    wr(`SAS_OFS_CTL0, 32'h17);
    repeat (50) @(posedge pclk);
    chk(afe.convert, 1'b1);
    chk(analog_pin_mask, 12'h000);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    chk(afe.convert, 1'b0);
    chk(analog_pin_mask, 12'hFFF);
    presetn <= 1'b1;
    rc(`SAS_OFS_CTL0, 32'h0);
    rc(`SAS_OFS_CTL2, 32'h0);
    tally_and_finish;
  end
endmodule // sar_adc_sequencer_bench

// >>> tb/sas_cmp_model.sv
`timescale 1ns/1ps
// ********************
// comparator model
// ********************
module sas_cmp_model (
  input  wire sas_pkg::sas_afe_t afe,     // front-end controls
  input  wire logic [9:0]        vin,     // held input as a code
  output logic                   comp_hi  // input at or above trial
);
  // outside a conversion the answer is meaningless, so it toggles with the trial code
  assign comp_hi = afe.convert ? (vin >= afe.trial) : ~afe.trial[0];
endmodule // sas_cmp_model
